/* File: bcs_charger.sv */
`timescale 1ns/1ns
`include "bcs_defines.svh"
module bcs_charger #(
  parameter int unsigned TICK_CYCLES = int'(`BCS_TICK_CYCLES),
  parameter int unsigned TRICKLE_TICKS = int'(`BCS_TRICKLE_TICKS),
  parameter int unsigned SAFETY_TICKS = int'(`BCS_SAFETY_TICKS),
  parameter int unsigned FILT_CYCLES = int'(`BCS_RECHG_FILT_CYCLES),
  parameter int unsigned NTC_HALF = int'(`BCS_NTC_HALF_CYCLES),
  parameter int unsigned BAD_HALF = int'(`BCS_BAD_HALF_CYCLES)
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Comparator and pin inputs, asynchronous.
  input wire logic batBelowTrickle,
  input wire logic batAtFloat,
  input wire logic batBelowRecharge,
  input wire logic chargeBelowTenth,
  input wire logic inputCurrentLimit,
  input wire logic tempFault,
  input wire logic inputAboveRising,
  input wire logic inputAboveBatRise,
  input wire logic inputAboveFalling,
  input wire logic inputAboveBatFall,
  input wire logic suspendSelect,
  input wire logic chargerEnablePin,
  // Open-drain charge status pin.
  input wire logic chargeStatusIn,
  output logic chargeStatusOut,
  output logic chargeStatusOe,
  // Regulator and current commands.
  output bcs_pkg::bcs_cmd_e chargeCurrentCmd,
  output logic switcherEnable,
  output logic suspendLdoEnable,
  // AXI4-Lite slave.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam logic [31:0] CARRIER = 32'(`BCS_CARRIER_CYCLES);

  bcs_pkg::bcs_regs_s st;
  bcs_pkg::bcs_regs_s nx;
  logic [`BCS_IN_COUNT-1:0] s;
  logic tick;
  logic ok;
  logic qual;
  logic restart;
  logic faultNtc;
  logic [31:0] half;
  logic [31:0] dutyNum;

  // Phase chosen at the start of a cycle: trickle or full current.
  function automatic bcs_pkg::bcs_state_e startState(input logic low);
    startState = low ? bcs_pkg::ST_TRICKLE : bcs_pkg::ST_CC;
  endfunction : startState

  // Carrier count below which the pin is pulled low.
  function automatic logic [31:0] dutyLimit(input logic [31:0] num);
    dutyLimit = 32'((64'(CARRIER) * 64'(num)) >> 4);
  endfunction : dutyLimit

  assign s = st.sync2;

  // Next-state logic for the whole block.
  always_comb begin
    nx = st;
    nx.sync1 = {chargeStatusIn, chargerEnablePin, suspendSelect, inputAboveBatFall,
                inputAboveFalling, inputAboveBatRise, inputAboveRising, tempFault,
                inputCurrentLimit, chargeBelowTenth, batBelowRecharge, batAtFloat,
                batBelowTrickle};
    nx.sync2 = st.sync1;
    nx.softRestart = 1'b0;
    // One prescaler feeds both long timers, so they share one clock source.
    tick = (st.tickCnt == TICK_CYCLES - 32'h0000_0001);
    nx.tickCnt = tick ? 32'h0000_0000 : st.tickCnt + 32'h0000_0001;
    // Hysteresis comes from using a different pair of comparators per direction.
    if (!st.uvloOk) begin
      nx.uvloOk = s[`BCS_IN_RISE] && s[`BCS_IN_BATRISE];
    end else begin
      nx.uvloOk = s[`BCS_IN_FALL] && s[`BCS_IN_BATFALL];
    end
    ok = s[`BCS_IN_EN] && st.ctrlEnable && st.uvloOk;
    nx.okLive = ok;
    restart = (ok && !st.okLive) || st.softRestart;
    // Recharge filter: a dip shorter than the window never qualifies.
    qual = 1'b0;
    if (!s[`BCS_IN_RECHG]) begin
      nx.filtCnt = 32'h0000_0000;
    end else if (st.filtCnt == FILT_CYCLES - 32'h0000_0001) begin
      qual = 1'b1;
      nx.filtCnt = 32'h0000_0000;
    end else begin
      nx.filtCnt = st.filtCnt + 32'h0000_0001;
    end
    // Charge sequence.
    unique case (st.state)
      bcs_pkg::ST_IDLE: begin
      end
      bcs_pkg::ST_TRICKLE: begin
        if (!s[`BCS_IN_TRKL]) begin
          nx.state = bcs_pkg::ST_CC;
        end else if (tick && !s[`BCS_IN_TEMP]) begin
          if (st.trickleCnt >= TRICKLE_TICKS) begin
            nx.state = bcs_pkg::ST_BAD;
          end else begin
            nx.trickleCnt = st.trickleCnt + 32'h0000_0001;
          end
        end
      end
      bcs_pkg::ST_CC: begin
        if (s[`BCS_IN_FLOAT]) begin
          nx.state = bcs_pkg::ST_CV;
          nx.safetyCnt = 32'h0000_0000;
        end
      end
      bcs_pkg::ST_CV: begin
        if (qual) begin
          nx.safetyCnt = 32'h0000_0000;
        end else if (tick && !s[`BCS_IN_TEMP]) begin
          if (st.safetyCnt >= SAFETY_TICKS - 32'h0000_0001) begin
            nx.state = bcs_pkg::ST_DONE;
          end else begin
            nx.safetyCnt = st.safetyCnt + 32'h0000_0001;
          end
        end
        // Current limit masks the one-tenth flag to avoid a false finish.
        if (s[`BCS_IN_FLOAT] && s[`BCS_IN_TENTH] && !s[`BCS_IN_ILIM]) begin
          nx.doneInd = 1'b1;
        end
      end
      bcs_pkg::ST_DONE: begin
        if (qual) begin
          restart = 1'b1;
        end
      end
      bcs_pkg::ST_BAD: begin
      end
      default: nx.state = bcs_pkg::ST_IDLE;
    endcase
    if (!ok) begin
      nx.state = bcs_pkg::ST_IDLE;
    end else if (restart || st.state == bcs_pkg::ST_IDLE) begin
      nx.state = startState(s[`BCS_IN_TRKL]);
      nx.trickleCnt = 32'h0000_0000;
      nx.safetyCnt = 32'h0000_0000;
      nx.doneInd = 1'b0;
    end
    // Temperature pause zeroes current but leaves the phase intact.
    if (s[`BCS_IN_TEMP]) begin
      nx.cmd = bcs_pkg::CMD_OFF;
    end else if (nx.state == bcs_pkg::ST_TRICKLE) begin
      nx.cmd = bcs_pkg::CMD_TRICKLE;
    end else if (nx.state == bcs_pkg::ST_CC || nx.state == bcs_pkg::ST_CV) begin
      nx.cmd = bcs_pkg::CMD_FULL;
    end else begin
      nx.cmd = bcs_pkg::CMD_OFF;
    end
    // Regulators.
    nx.switcherEn = nx.uvloOk && !s[`BCS_IN_SUSP];
    nx.suspendLdoEn = s[`BCS_IN_SUSP] && !nx.switcherEn;
    // Status carrier and blink phase run free, so the host sees steady timing.
    nx.carrierCnt = (st.carrierCnt == CARRIER - 32'h0000_0001) ? 32'h0000_0000 :
                    st.carrierCnt + 32'h0000_0001;
    faultNtc = s[`BCS_IN_TEMP] && nx.state != bcs_pkg::ST_BAD &&
               nx.state != bcs_pkg::ST_IDLE && nx.state != bcs_pkg::ST_DONE;
    half = faultNtc ? NTC_HALF : BAD_HALF;
    if (st.blinkCnt >= half - 32'h0000_0001) begin
      nx.blinkCnt = 32'h0000_0000;
      nx.blinkPhase = !st.blinkPhase;
    end else begin
      nx.blinkCnt = st.blinkCnt + 32'h0000_0001;
    end
    if (faultNtc) begin
      dutyNum = nx.blinkPhase ? `BCS_NTC_DUTY_HI : `BCS_NTC_DUTY_LO;
    end else begin
      dutyNum = nx.blinkPhase ? `BCS_BAD_DUTY_HI : `BCS_BAD_DUTY_LO;
    end
    if (nx.state == bcs_pkg::ST_BAD || faultNtc) begin
      nx.statusOe = nx.carrierCnt < dutyLimit(dutyNum);
    end else if (nx.state == bcs_pkg::ST_TRICKLE || nx.state == bcs_pkg::ST_CC ||
                 nx.state == bcs_pkg::ST_CV) begin
      nx.statusOe = !nx.doneInd;
    end else begin
      nx.statusOe = 1'b0;
    end
    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && st.awready) begin
      nx.awHave = 1'b1;
      nx.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      nx.wHave = 1'b1;
      nx.wData = s_axi_wdata;
      nx.wStrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      nx.bvalid = 1'b0;
    end
    if (st.awHave && st.wHave && !st.bvalid) begin
      nx.awHave = 1'b0;
      nx.wHave = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = `BCS_RESP_OKAY;
      if (st.awAddr[11:2] == `BCS_REG_CTRL >> 2) begin
        if (st.wStrb[0]) begin
          nx.ctrlEnable = st.wData[`BCS_CTRL_ENABLE];
          nx.softRestart = st.wData[`BCS_CTRL_RESTART];
        end
      end else if (st.awAddr[11:2] != `BCS_REG_STATUS >> 2 &&
                   st.awAddr[11:2] != `BCS_REG_TIMER >> 2) begin
        nx.bresp = `BCS_RESP_SLVERR;
      end
    end
    nx.awready = !nx.awHave && !nx.bvalid;
    nx.wready = !nx.wHave && !nx.bvalid;
    // Read channel: one cycle from address to data.
    if (st.rvalid && s_axi_rready) begin
      nx.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      nx.rvalid = 1'b1;
      nx.rresp = `BCS_RESP_OKAY;
      nx.rdata = 32'h0000_0000;
      unique case (s_axi_araddr[11:2])
        `BCS_REG_CTRL >> 2: nx.rdata = {31'h0000_0000, st.ctrlEnable};
        `BCS_REG_STATUS >> 2: nx.rdata = {18'h0_0000, s[`BCS_IN_PIN], s[`BCS_IN_TEMP],
                                          st.doneInd, st.statusOe, st.suspendLdoEn,
                                          st.switcherEn, st.cmd, st.state};
        `BCS_REG_TIMER >> 2: nx.rdata = st.safetyCnt;
        default: nx.rresp = `BCS_RESP_SLVERR;
      endcase
    end
    nx.arready = !nx.rvalid;
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
      st.state <= bcs_pkg::ST_IDLE;
      st.ctrlEnable <= `BCS_CTRL_RST;
    end else begin
      st <= nx;
    end
  end

  // Outputs come straight from the state register.
  assign chargeStatusOut = st.statusOut;
  assign chargeStatusOe = st.statusOe;
  assign chargeCurrentCmd = st.cmd;
  assign switcherEnable = st.switcherEn;
  assign suspendLdoEnable = st.suspendLdoEn;
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  // Checks on the sequence and the outputs.
  a_trickle_cmd: assert property (@(posedge clk) disable iff (!nrst)
    (st.state == bcs_pkg::ST_TRICKLE && !s[`BCS_IN_TEMP] && !$past(s[`BCS_IN_TEMP]))
    |-> chargeCurrentCmd == bcs_pkg::CMD_TRICKLE) else $error("trickle cmd wrong");
  a_bad_entry: assert property (@(posedge clk) disable iff (!nrst)
    $rose(st.state == bcs_pkg::ST_BAD) |-> $past(st.state) == bcs_pkg::ST_TRICKLE &&
    $past(st.trickleCnt) >= TRICKLE_TICKS) else $error("bad battery entry wrong");
  a_cc_leave: assert property (@(posedge clk) disable iff (!nrst)
    (st.state == bcs_pkg::ST_TRICKLE && !s[`BCS_IN_TRKL] && ok && !restart)
    |=> st.state == bcs_pkg::ST_CC) else $error("trickle not left");
  a_timer_start: assert property (@(posedge clk) disable iff (!nrst)
    $rose(st.state == bcs_pkg::ST_CV) |-> st.safetyCnt == 32'h0000_0000)
    else $error("safety timer not cleared");
  a_done_off: assert property (@(posedge clk) disable iff (!nrst)
    st.state == bcs_pkg::ST_DONE |-> chargeCurrentCmd == bcs_pkg::CMD_OFF)
    else $error("current after done");
  a_recharge_go: assert property (@(posedge clk) disable iff (!nrst)
    (st.state == bcs_pkg::ST_DONE && qual && ok)
    |=> st.state inside {bcs_pkg::ST_TRICKLE, bcs_pkg::ST_CC}) else $error("no recharge");
  a_timer_clear: assert property (@(posedge clk) disable iff (!nrst)
    (st.state == bcs_pkg::ST_CV && qual) |=> st.safetyCnt == 32'h0000_0000)
    else $error("timer not cleared");
  a_filter_len: assert property (@(posedge clk) disable iff (!nrst)
    qual |-> st.filtCnt == FILT_CYCLES - 32'h0000_0001 && s[`BCS_IN_RECHG])
    else $error("filter too short");
  a_uvlo_rise: assert property (@(posedge clk) disable iff (!nrst)
    $rose(st.uvloOk) |-> $past(s[`BCS_IN_RISE] && s[`BCS_IN_BATRISE]))
    else $error("switcher enabled early");
  a_suspend_excl: assert property (@(posedge clk) disable iff (!nrst)
    !(switcherEnable && suspendLdoEnable)) else $error("both regulators on");
  a_temp_freeze: assert property (@(posedge clk) disable iff (!nrst)
    (st.state == bcs_pkg::ST_CV && s[`BCS_IN_TEMP] && nx.state == bcs_pkg::ST_CV)
    |=> st.safetyCnt <= $past(st.safetyCnt)) else $error("timer ran in fault");
  // The pin is low in trickle and constant current and released in CV once done, outside a temperature pause.
  a_charge_low: assert property (@(posedge clk) disable iff (!nrst)
    (st.state inside {bcs_pkg::ST_TRICKLE, bcs_pkg::ST_CC} && !$past(s[`BCS_IN_TEMP]))
    |-> chargeStatusOe) else $error("status pin not low while charging");
  a_pin_release: assert property (@(posedge clk) disable iff (!nrst)
    (st.state == bcs_pkg::ST_CV && st.doneInd && !$past(s[`BCS_IN_TEMP]))
    |-> !chargeStatusOe) else $error("status pin not released");

endmodule : bcs_charger

/* File: bcs_defines.svh */
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH
// Clock and derived timing.
`define BCS_CLK_HZ 64'd100000000
`define BCS_TICK_MS 64'd1
`define BCS_TICK_CYCLES (`BCS_CLK_HZ * `BCS_TICK_MS / 64'd1000)
`define BCS_TRICKLE_TIMEOUT_S 64'd1800
`define BCS_TRICKLE_TICKS (`BCS_TRICKLE_TIMEOUT_S * 64'd1000 / `BCS_TICK_MS)
`define BCS_SAFETY_TIMEOUT_S 64'd14400
`define BCS_SAFETY_TICKS (`BCS_SAFETY_TIMEOUT_S * 64'd1000 / `BCS_TICK_MS)
`define BCS_RECHG_FILT_US 64'd1300
`define BCS_RECHG_FILT_CYCLES (`BCS_CLK_HZ * `BCS_RECHG_FILT_US / 64'd1000000 + 64'd1)
`define BCS_CARRIER_HZ 64'd35000
`define BCS_CARRIER_CYCLES (`BCS_CLK_HZ / `BCS_CARRIER_HZ)
`define BCS_NTC_BLINK_MHZ 64'd1500
`define BCS_BAD_BLINK_MHZ 64'd6100
`define BCS_NTC_HALF_CYCLES (`BCS_CLK_HZ * 64'd1000 / (64'd2 * `BCS_NTC_BLINK_MHZ))
`define BCS_BAD_HALF_CYCLES (`BCS_CLK_HZ * 64'd1000 / (64'd2 * `BCS_BAD_BLINK_MHZ))
// Duty cycles in sixteenths of the carrier period.
`define BCS_NTC_DUTY_LO 32'h0000_0001
`define BCS_NTC_DUTY_HI 32'h0000_000F
`define BCS_BAD_DUTY_LO 32'h0000_0002
`define BCS_BAD_DUTY_HI 32'h0000_000E
// Register offsets and fields.
`define BCS_REG_CTRL 12'h000
`define BCS_REG_STATUS 12'h004
`define BCS_REG_TIMER 12'h008
`define BCS_CTRL_ENABLE 0
`define BCS_CTRL_RESTART 1
`define BCS_CTRL_RST 1'b1
`define BCS_RESP_OKAY 2'h0
`define BCS_RESP_SLVERR 2'h2
// Synchronised input bit positions.
`define BCS_IN_TRKL 0
`define BCS_IN_FLOAT 1
`define BCS_IN_RECHG 2
`define BCS_IN_TENTH 3
`define BCS_IN_ILIM 4
`define BCS_IN_TEMP 5
`define BCS_IN_RISE 6
`define BCS_IN_BATRISE 7
`define BCS_IN_FALL 8
`define BCS_IN_BATFALL 9
`define BCS_IN_SUSP 10
`define BCS_IN_EN 11
`define BCS_IN_PIN 12
`define BCS_IN_COUNT 13
`endif

/* File: bcs_pkg.sv */
package bcs_pkg;
  `include "bcs_defines.svh"
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001, ST_TRICKLE = 6'b000010, ST_CC = 6'b000100,
    ST_CV = 6'b001000, ST_DONE = 6'b010000, ST_BAD = 6'b100000
  } bcs_state_e;
  typedef enum logic [1:0] {
    CMD_OFF = 2'h0, CMD_TRICKLE = 2'h1, CMD_FULL = 2'h2
  } bcs_cmd_e;
  typedef struct packed {
    logic [`BCS_IN_COUNT-1:0] sync1;
    logic [`BCS_IN_COUNT-1:0] sync2;
    bcs_state_e state;
    logic [31:0] tickCnt;
    logic [31:0] trickleCnt;
    logic [31:0] safetyCnt;
    logic [31:0] filtCnt;
    logic [31:0] carrierCnt;
    logic [31:0] blinkCnt;
    logic blinkPhase;
    logic uvloOk;
    logic okLive;
    logic doneInd;
    logic ctrlEnable;
    logic softRestart;
    bcs_cmd_e cmd;
    logic switcherEn;
    logic suspendLdoEn;
    logic statusOut;
    logic statusOe;
    logic awHave;
    logic [11:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bcs_regs_s;
endpackage : bcs_pkg

/* File: bcs_host_model.sv */
`timescale 1ns/1ns
module bcs_host_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Status pin level as seen through the pull-up.
  input wire logic pinLevel,
  input wire logic clrSeen,
  // Decoded duty codes in sixteenths and the last carrier period.
  output logic [16:0] seenCodes,
  output logic [31:0] lastPeriod
);
  logic [31:0] perCnt;
  logic [31:0] lowCnt;
  logic prevLevel;

  // A period runs from one falling edge of the pin to the next; the low time inside it is
  // turned into a duty code. The first period after a steady stretch is junk, so callers
  // clear the record first and look only at the codes that they expect.
  always @(posedge clk) begin
    if (!nrst || clrSeen) begin
      seenCodes <= '0;
      lastPeriod <= '0;
      perCnt <= '0;
      lowCnt <= '0;
      prevLevel <= 1'b1;
    end else begin
      prevLevel <= pinLevel;
      if (prevLevel && !pinLevel) begin
        lastPeriod <= perCnt;
        perCnt <= 32'h0000_0001;
        lowCnt <= 32'h0000_0001;
        // A reading of exactly one half straddles a blink edge and is thrown away.
        if (perCnt != 0 && 2 * lowCnt != perCnt) begin
          seenCodes[(lowCnt * 16 + perCnt / 2) / perCnt] <= 1'b1;
        end
      end else begin
        perCnt <= perCnt + 1;
        lowCnt <= lowCnt + 32'(!pinLevel);
      end
    end
  end
endmodule : bcs_host_model

/* File: tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic clk, nrst, bTrk, flt, rchg, tenth, ilim, tmp, rise, bRise, fall, bFall, susp, en, clr;
  logic oeS, outS, swEn, ldoEn, awV, wV, bR, arV, rR, awRdy, wRdy, bV, arRdy, rV;
  logic [11:0] awA, arA;
  logic [31:0] wD, rD, d, t1, per;
  logic [3:0] wS;
  logic [1:0] bRsp, rRsp, r;
  logic [16:0] seen;
  bcs_pkg::bcs_cmd_e cmd;
  wire pin;
  int errTotal = 0;
  int testsRun = 0;

  // Open-drain wire with a pull-up: low only while the block enables its driver.
  assign pin = oeS ? outS : 1'b1;

  // Short timer parameters keep the run brief; all counts derive from the one clock.
  // Blink halves are whole carrier periods, so every phase holds one clean period.
  bcs_charger #(.TICK_CYCLES(4), .TRICKLE_TICKS(50), .SAFETY_TICKS(50),
    .FILT_CYCLES(8), .NTC_HALF(8571), .BAD_HALF(5714)) dut (
    .clk(clk), .nrst(nrst), .batBelowTrickle(bTrk), .batAtFloat(flt),
    .batBelowRecharge(rchg), .chargeBelowTenth(tenth), .inputCurrentLimit(ilim),
    .tempFault(tmp), .inputAboveRising(rise), .inputAboveBatRise(bRise),
    .inputAboveFalling(fall), .inputAboveBatFall(bFall), .suspendSelect(susp),
    .chargerEnablePin(en), .chargeStatusIn(pin), .chargeStatusOut(outS),
    .chargeStatusOe(oeS), .chargeCurrentCmd(cmd), .switcherEnable(swEn),
    .suspendLdoEnable(ldoEn), .s_axi_awaddr(awA), .s_axi_awvalid(awV),
    .s_axi_awready(awRdy), .s_axi_wdata(wD), .s_axi_wstrb(wS), .s_axi_wvalid(wV),
    .s_axi_wready(wRdy), .s_axi_bresp(bRsp), .s_axi_bvalid(bV), .s_axi_bready(bR),
    .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy), .s_axi_rdata(rD),
    .s_axi_rresp(rRsp), .s_axi_rvalid(rV), .s_axi_rready(rR));

  bcs_host_model host (.clk(clk), .nrst(nrst), .pinLevel(pin), .clrSeen(clr),
    .seenCodes(seen), .lastPeriod(per));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // Each channel is released at the edge where its ready is seen; bready stays up until bvalid.
  task axw(input logic [11:0] a, input logic [31:0] dat, input logic [3:0] sb,
           output logic [1:0] rs);
    awA <= a;
    wD <= dat;
    wS <= sb;
    awV <= 1'b1;
    wV <= 1'b1;
    bR <= 1'b1;
    do begin
      @(posedge clk);
      if (awRdy) awV <= 1'b0;
      if (wRdy) wV <= 1'b0;
    end while (!bV);
    rs = bRsp;
    bR <= 1'b0;
  endtask : axw

  task axr(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] rs);
    arA <= a;
    arV <= 1'b1;
    rR <= 1'b1;
    do begin
      @(posedge clk);
      if (arRdy) arV <= 1'b0;
    end while (!rV);
    dat = rD;
    rs = rRsp;
    rR <= 1'b0;
    // One idle edge keeps a following read from raising rready in the same step.
    cyc(1);
  endtask : axr

  task clrHost;
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
  endtask : clrHost

  task summarize;
    if (errTotal == 0 && testsRun > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // A hang counts as a failure and ends the run through the same verdict.
  initial begin
    cyc(80000);
    errTotal++;
    summarize;
  end

  // Main sequence: supply gating, one full charge cycle, faults, restarts.
  initial begin
    {clk, nrst, bTrk, flt, rchg, tenth, ilim, tmp, rise, bRise, fall, bFall, susp, en} = '0;
    {clr, awV, wV, bR, arV, rR, awA, arA, wD, wS} = '0;
    cyc(5);
    nrst <= 1'b1;
    cyc(2);
    axr(12'h000, d, r);
    chk(d[0], 1, "ctrl reset");
    axr(12'h00C, d, r);
    chk(r, 2'h2, "unmapped read resp");
    chk(d, 32'h0000_0000, "unmapped read data");
    axw(12'h010, 32'h0000_0001, 4'hF, r);
    chk(r, 2'h2, "unmapped write");
    {rise, fall, bFall} <= 3'b111;
    cyc(10);
    chk(swEn, 0, "switcher without margin");
    bRise <= 1'b1;
    cyc(10);
    chk(swEn, 1, "switcher on");
    {rise, bRise} <= 2'b00;
    cyc(10);
    chk(swEn, 1, "hysteresis hold");
    bFall <= 1'b0;
    cyc(10);
    chk(swEn, 0, "switcher off");
    {bFall, rise, bRise} <= 3'b111;
    susp <= 1'b1;
    cyc(10);
    chk({swEn, ldoEn}, 2'b01, "suspend");
    susp <= 1'b0;
    cyc(10);
    chk({swEn, ldoEn}, 2'b10, "resume");
    {rise, fall} <= 2'b00;
    cyc(10);
    chk(swEn, 0, "below falling");
    {rise, fall} <= 2'b11;
    cyc(10);
    chk(swEn, 1, "switcher back");
    {bTrk, en} <= 2'b11;
    cyc(10);
    chk(cmd, bcs_pkg::CMD_TRICKLE, "trickle");
    chk(pin, 0, "charging low");
    bTrk <= 1'b0;
    cyc(10);
    chk(cmd, bcs_pkg::CMD_FULL, "full current");
    flt <= 1'b1;
    cyc(60);
    axr(12'h008, t1, r);
    chk(t1 != 0, 1, "safety timer runs");
    chk(cmd, bcs_pkg::CMD_FULL, "cv charging");
    rchg <= 1'b1;
    cyc(20);
    rchg <= 1'b0;
    cyc(4);
    axr(12'h008, d, r);
    chk(d < t1, 1, "timer cleared");
    tmp <= 1'b1;
    cyc(10);
    chk(cmd, bcs_pkg::CMD_OFF, "temp pause");
    axr(12'h008, t1, r);
    clrHost;
    cyc(26000);
    axr(12'h008, d, r);
    chk(d, t1, "timer frozen");
    chk(seen[1] && seen[15], 1, "temp duty codes");
    chk(per, 2857, "carrier period");
    tmp <= 1'b0;
    cyc(10);
    chk(cmd, bcs_pkg::CMD_FULL, "phase resumed");
    {ilim, tenth} <= 2'b11;
    cyc(10);
    chk(pin, 0, "limit masks tenth");
    ilim <= 1'b0;
    cyc(10);
    chk(pin, 1, "released");
    cyc(250);
    chk(cmd, bcs_pkg::CMD_OFF, "terminated");
    axr(12'h004, d, r);
    chk(d[5:0], 6'b010000, "done state");
    tenth <= 1'b0;
    rchg <= 1'b1;
    cyc(4);
    rchg <= 1'b0;
    cyc(20);
    chk(cmd, bcs_pkg::CMD_OFF, "short dip ignored");
    rchg <= 1'b1;
    cyc(20);
    rchg <= 1'b0;
    cyc(4);
    chk(cmd, bcs_pkg::CMD_FULL, "recharge");
    chk(pin, 0, "charging low again");
    {en, flt, bTrk} <= 3'b001;
    cyc(10);
    en <= 1'b1;
    cyc(10);
    chk(cmd, bcs_pkg::CMD_TRICKLE, "enable restart");
    cyc(300);
    chk(cmd, bcs_pkg::CMD_OFF, "bad battery");
    clrHost;
    cyc(17200);
    chk(seen[2] && seen[14], 1, "bad duty codes");
    chk(per, 2857, "carrier period");
    axr(12'h004, d, r);
    chk(d[5:0], 6'b100000, "bad state");
    // The host lightens its load and cycles the enable pin to retry.
    {bTrk, en} <= 2'b00;
    cyc(10);
    en <= 1'b1;
    cyc(10);
    chk(cmd, bcs_pkg::CMD_FULL, "retry");
    axw(12'h000, 32'h0000_0000, 4'hF, r);
    cyc(10);
    chk(cmd, bcs_pkg::CMD_OFF, "ctrl gate");
    axw(12'h000, 32'h0000_0001, 4'hF, r);
    cyc(10);
    chk(cmd, bcs_pkg::CMD_FULL, "ctrl restart");
    // A write without the low byte strobe must leave the control bits alone.
    axw(12'h000, 32'h0000_0000, 4'hE, r);
    cyc(10);
    chk(cmd, bcs_pkg::CMD_FULL, "strobe masks ctrl");
    chk(r, 2'h0, "ctrl write okay");
    flt <= 1'b1;
    cyc(60);
    axr(12'h008, t1, r);
    axw(12'h000, 32'h0000_0003, 4'h1, r);
    axr(12'h008, d, r);
    chk(d < t1, 1, "soft restart clears timer");
    summarize;
  end
endmodule : tb_top
